/* File: common/comparator_bank_defines.vh */
`ifndef COMPARATOR_BANK_DEFINES_VH
`define COMPARATOR_BANK_DEFINES_VH

`define CTRL1_ADDR        12'h000
`define CTRL2_ADDR        12'h004
`define CTRL3_ADDR        12'h008
`define STATUS_ADDR       12'h00c
`define IDLE_ADDR         12'h010

`define CTRL_RESET        16'h0000
`define CTRL_WMASK        16'hf2db

`define BIT_ENABLE        15
`define BIT_PIN_DRIVE     14
`define BIT_INVERT        13
`define BIT_LOW_POWER     12
`define BIT_EVENT         9
`define BIT_RESULT        8
`define EDGE_HI           7
`define EDGE_LO           6
`define REF_HI            4
`define REF_LO            3
`define CHAN_HI           1
`define CHAN_LO           0

`define EDGE_NONE         2'b00
`define EDGE_RISE         2'b01
`define EDGE_FALL         2'b10
`define EDGE_ANY          2'b11

`define STAT_EVENT_LO     8
`define STAT_IDLE_STOP    15

`endif

/* File: src/comparator_channel.v */
`timescale 1ns/1ns
`default_nettype none
`include "comparator_bank_defines.vh"

module comparator_channel
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        raw_compare,
  input  wire [1:0]  edge_select,
  input  wire        invert,
  input  wire        enable,
  input  wire        event_clear,
  input  wire        config_write,
  output reg         compare_result,
  output reg         event_flag,
  output reg         event_pulse
);

  // Three flops; a change counts once the second and third agree.
  reg        sync1;
  reg        sync2;
  reg        sync3;
  reg        first_pending;
  wire       next_result;
  wire       rising;
  wire       falling;
  reg        hit;

  assign next_result = (sync2 == sync3) ? (sync3 ^ invert) : compare_result;
  assign rising      = !compare_result && next_result;
  assign falling     = compare_result && !next_result;

  always @*
  begin
    hit = 1'b0;
    if (first_pending)
      hit = rising || falling;
    else
      case (edge_select)
        `EDGE_RISE: hit = rising;
        `EDGE_FALL: hit = falling;
        `EDGE_ANY:  hit = rising || falling;
        default:    hit = 1'b0;
      endcase
    if (edge_select == `EDGE_NONE || !enable)
      hit = 1'b0;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1          <= 1'b0;
      sync2          <= 1'b0;
      sync3          <= 1'b0;
      compare_result <= 1'b0;
      event_flag     <= 1'b0;
      event_pulse    <= 1'b0;
      first_pending  <= 1'b1;
    end
    else if (clk_en)
    begin
      sync1          <= raw_compare;
      sync2          <= sync1;
      sync3          <= sync2;
      compare_result <= enable ? next_result : 1'b0;
      event_pulse    <= hit && !event_flag;
      // A new event wins over a clear in the same cycle only while the flag is clear; with the flag set, the clear wins.
      if (hit && !event_flag)
        event_flag <= 1'b1;
      else if (event_clear)
        event_flag <= 1'b0;
      if (config_write)
        first_pending <= 1'b1;
      else if (hit && !event_flag)
        first_pending <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: src/comparator_bank.v */
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "comparator_bank_defines.vh"

module comparator_bank
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [2:0]  raw_compare,
  input  wire        idle_mode,
  output reg  [2:0]  comparator_enable,
  output reg  [2:0]  low_power_select,
  output reg  [5:0]  inverting_channel_select,
  output reg  [5:0]  reference_select,
  output reg  [2:0]  result_pin_drive,
  output reg  [2:0]  result_output_pin,
  output reg  [2:0]  interrupt_request
);

  reg  [15:0] ctrl [0:2];
  reg         idle_interrupt_stop;
  reg         idle_sync1;
  reg         idle_sync2;
  reg         idle_sync3;
  reg         idle_seen;
  reg  [31:0] next_rdata;
  reg         next_err;
  wire [2:0]  compare_result;
  wire [2:0]  event_flag;
  wire [2:0]  event_pulse;
  wire        setup;
  wire        wr;
  wire [15:0] status;

  assign setup = psel && !penable;
  assign wr    = psel && penable && pready && pwrite;
  assign status = {idle_interrupt_stop, 4'h0, event_flag, 5'h00,
                   compare_result};

  // -------------------------------------------------------------------
  // Per-channel control and event logic
  // -------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : chan
      wire sel;
      wire ev_clr;
      assign sel = (paddr == ((g == 0) ? `CTRL1_ADDR :
                              (g == 1) ? `CTRL2_ADDR : `CTRL3_ADDR));
      // Writing 0 to the event bit clears it; writing 1 leaves it alone.
      assign ev_clr = wr && sel && !pwdata[`BIT_EVENT];

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ctrl[g] <= `CTRL_RESET;
        else if (clk_en && wr && sel)
          ctrl[g] <= pwdata[15:0] & `CTRL_WMASK;
      end

      comparator_channel u_chan
      (
        .pclk           (pclk),
        .presetn        (presetn),
        .clk_en         (clk_en),
        .raw_compare    (raw_compare[g]),
        .edge_select    (ctrl[g][`EDGE_HI:`EDGE_LO]),
        .invert         (ctrl[g][`BIT_INVERT]),
        .enable         (ctrl[g][`BIT_ENABLE]),
        .event_clear    (ev_clr),
        .config_write   (wr && sel),
        .compare_result (compare_result[g]),
        .event_flag     (event_flag[g]),
        .event_pulse    (event_pulse[g])
      );

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          comparator_enable[g]           <= 1'b0;
          low_power_select[g]            <= 1'b0;
          inverting_channel_select[2*g+1 -: 2] <= 2'b00;
          reference_select[2*g+1 -: 2]   <= 2'b00;
          result_pin_drive[g]            <= 1'b0;
          result_output_pin[g]           <= 1'b0;
          interrupt_request[g]           <= 1'b0;
        end
        else if (clk_en)
        begin
          comparator_enable[g] <= ctrl[g][`BIT_ENABLE];
          low_power_select[g]  <= ctrl[g][`BIT_LOW_POWER];
          // Codes go to the analog mux: 11 band-gap, 10/01/00 pins.
          inverting_channel_select[2*g+1 -: 2] <=
            ctrl[g][`CHAN_HI:`CHAN_LO];
          reference_select[2*g+1 -: 2] <= ctrl[g][`REF_HI:`REF_LO];
          result_pin_drive[g]  <= ctrl[g][`BIT_PIN_DRIVE];
          // Pin value is registered here only as a digital mirror; the pad
          // itself routes the unsynchronised analog result when drive is on.
          result_output_pin[g] <= ctrl[g][`BIT_PIN_DRIVE] &&
                                  ctrl[g][`BIT_ENABLE] &&
                                  (raw_compare[g] ^ ctrl[g][`BIT_INVERT]);
          interrupt_request[g] <= event_pulse[g] &&
                                  !(idle_interrupt_stop && idle_seen);
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------------
  // Idle input and APB slave
  // -------------------------------------------------------------------
  always @*
  begin
    next_err   = 1'b0;
    next_rdata = 32'h00000000;
    case (paddr)
      `CTRL1_ADDR:  next_rdata = {16'h0000, ctrl[0][15:10],
                                  event_flag[0], compare_result[0],
                                  ctrl[0][7:0]};
      `CTRL2_ADDR:  next_rdata = {16'h0000, ctrl[1][15:10],
                                  event_flag[1], compare_result[1],
                                  ctrl[1][7:0]};
      `CTRL3_ADDR:  next_rdata = {16'h0000, ctrl[2][15:10],
                                  event_flag[2], compare_result[2],
                                  ctrl[2][7:0]};
      `STATUS_ADDR: next_rdata = {16'h0000, status};
      `IDLE_ADDR:   next_rdata = {31'h00000000, idle_interrupt_stop};
      default:      next_err   = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata              <= 32'h00000000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      idle_interrupt_stop <= 1'b0;
      idle_sync1          <= 1'b0;
      idle_sync2          <= 1'b0;
      idle_sync3          <= 1'b0;
      idle_seen           <= 1'b0;
    end
    else if (clk_en)
    begin
      idle_sync1 <= idle_mode;
      idle_sync2 <= idle_sync1;
      idle_sync3 <= idle_sync2;
      if (idle_sync2 == idle_sync3)
        idle_seen <= idle_sync3;
      // No wait state: ready rises in the first access cycle, the cycle after setup.
      pready  <= setup;
      pslverr <= setup && next_err;
      if (setup && !pwrite)
        prdata <= next_rdata;
      if (wr && (paddr == `IDLE_ADDR || paddr == `STATUS_ADDR))
        idle_interrupt_stop <= pwdata[0] ^ (paddr == `STATUS_ADDR ?
          (pwdata[`STAT_IDLE_STOP] ^ pwdata[0]) : 1'b0);
    end
  end

endmodule
`default_nettype wire

/* File: verification/comparator_bank_props.sv */
`timescale 1ns/1ns
`default_nettype none
module comparator_bank_props
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  result_pin_drive,
  input wire logic [2:0]  result_output_pin,
  input wire logic [2:0]  interrupt_request
);
  // ----------------------------------------------------------
  // Bus, pin and event checks
  // ----------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_one_a: assert property (pready && clk_en |=> !pready)
    else $error("pready held");
  ready_wait_a: assert property (psel && !penable && clk_en |=> pready)
    else $error("no answer");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("stray pready");
  err_map_a: assert property (pready |-> pslverr ==
    !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010}))
    else $error("bad slave error");
  err_data_a: assert property (pslverr |->
    pready && (pwrite || prdata == 0))
    else $error("bad error read");
  pin_gate_a: assert property ((result_output_pin & ~(result_pin_drive |
    $past(result_pin_drive))) == 0) else $error("pin undriven");
  irq_single_a: assert property (|interrupt_request && clk_en |=>
    (interrupt_request & $past(interrupt_request)) == 0)
    else $error("repeated event");
  freeze_all_a: assert property (!clk_en |=>
    $stable({pready, interrupt_request})) else $error("moved");
  cover property (pready && pslverr);
  cover property (|interrupt_request);
  cover property (|result_output_pin);
endmodule
`default_nettype wire

/* File: verification/analog_inputs.sv */
`timescale 1ns/1ns
`default_nettype none
module analog_inputs
(
  input wire logic       slow,
  input wire logic [2:0] level,
  output var logic [2:0] raw_compare
);
  // A slow comparator settles late, so nothing may rely on its speed.
  always @(level) raw_compare <= #(slow ? 40 : 1) level;
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
  logic        pwrite = 0, idle_mode = 0, slow = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [2:0]  level = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  wire  [2:0]  raw, en, lp, pd, pin, irq;
  wire  [5:0]  ch, rf;
  int          bad_count = 0, n_compared = 0;
  comparator_bank u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_compare(raw), .idle_mode(idle_mode), .comparator_enable(en),
    .low_power_select(lp), .inverting_channel_select(ch),
    .reference_select(rf), .result_pin_drive(pd),
    .result_output_pin(pin), .interrupt_request(irq));
  analog_inputs u_far (.slow(slow), .level(level), .raw_compare(raw));
  initial forever #5 pclk = ~pclk;
  // ----------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------
  task automatic complete_run;
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20)
    begin
      bad_count++;
      complete_run;
    end
  endtask
  // Counts channel-0 interrupt requests over a window long enough for the sync chain.
  task automatic watch(input int exp);
    int h;
    h = 0;
    repeat (20) begin @(posedge pclk); h += (irq[0] === 1); end
    chk(h, exp);
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    for (int a = 0; a < 16; a += 4)
    begin
      apb(0, a[11:0], 0);
      chk(rd, 0);
    end
    for (int c = 0; c < 4; c++)
    begin
      apb(1, 12'h004, {27'h0, c[1:0], 1'b0, c[1:0]});
      repeat (2) @(posedge pclk);
      chk(ch[3:2], c);
      chk(rf[3:2], c);
    end
    apb(0, 12'h000, 0);
    chk(rd, 0);
    $display("selects done");
    apb(1, 12'h000, 32'hd08a);
    apb(0, 12'h000, 0);
    chk(rd, 32'hd08a);
    chk({en[0], lp[0], pd[0]}, 3'b111);
    level <= 3'b001;
    watch(1);
    apb(0, 12'h00c, 0);
    chk(rd, 32'h101);
    chk(pin[0], 1);
    level <= 0;
    watch(0);
    apb(1, 12'h000, 32'hd08a);
    slow <= 1;
    level <= 1;
    watch(1);
    apb(1, 12'h000, 32'hd00a);
    level <= 0;
    watch(0);
    $display("events done");
    apb(1, 12'h010, 1);
    idle_mode <= 1;
    apb(1, 12'h000, 32'hd08a);
    level <= 1;
    watch(0);
    apb(0, 12'h00c, 0);
    chk(rd, 32'h8101);
    idle_mode <= 0;
    apb(0, 12'h100, 0);
    chk(err, 1);
    chk(rd, 0);
    clk_en <= 0;
    level <= 0;
    repeat (5) @(posedge pclk);
    clk_en <= 1;
    $display("idle and map done");
    complete_run;
  end
endmodule
bind comparator_bank comparator_bank_props u_props (.*);
`default_nettype wire
